// >>> hdl/pcrs_clock_monitor.sv
// Edge-based presence detector for a clock arriving on a pin
`default_nettype none

module pcrs_clock_monitor
    import pcrs_pkg::*;
#(
    parameter int                      CNT_W   = PCRS_WIN_CNT_W,
    parameter logic [CNT_W-1:0]        WIN_CYC = CNT_W'(PCRS_LF_WIN_CYC)
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  clk_pin_i,
    output logic                       level_o,
    output logic                       seen_o
);

    logic             sync1_reg;
    logic             sync2_reg;
    logic             last_reg;
    logic [CNT_W-1:0] quiet_reg;
    logic [CNT_W-1:0] quiet_next;
    logic             seen_reg;
    logic             seen_next;

    // Sampling only: a fast pin clock aliases but still shows transitions
    always_comb begin
        quiet_next = quiet_reg;
        seen_next  = seen_reg;
        if (sync2_reg != last_reg) begin
            quiet_next = '0;
            seen_next  = 1'b1;
        end else if (quiet_reg == WIN_CYC) begin
            seen_next  = 1'b0;
        end else begin
            quiet_next = quiet_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        sync1_reg <= clk_pin_i;
        sync2_reg <= sync1_reg;
        last_reg  <= sync2_reg;
        if (sys_rst_i) begin
            quiet_reg <= '0;
            seen_reg  <= 1'b0;
        end else begin
            quiet_reg <= quiet_next;
            seen_reg  <= seen_next;
        end
    end

    assign level_o = sync2_reg;
    assign seen_o  = seen_reg;

endmodule // pcrs_clock_monitor

`default_nettype wire

// >>> hdl/pcrs_pkg.sv
// Constants shared by the power, clock and reset status block
`default_nettype none

package pcrs_pkg;

    // Register byte offsets
    localparam logic [7:0]  PCRS_SLEEP_CMD_OFS     = 8'h24;
    localparam logic [7:0]  PCRS_CLK_NEED_OFS      = 8'h28;
    localparam logic [7:0]  PCRS_SLOW_DIV_OFS      = 8'h2c;
    localparam logic [7:0]  PCRS_OSCILLATOR_LOCKED_OFS      = 8'h30;
    localparam logic [7:0]  PCRS_PWR_RST_OFS       = 8'h34;

    // Peripheral bit map shared by the sleep command and clock need registers
    localparam logic [31:0] PCRS_PERIPH_MASK       = 32'h007fffe8;
    localparam logic [31:0] PCRS_SLEEP_CMD_RST     = 32'h00000000;

    // Slow clock divider field
    localparam int          PCRS_SLOW_DIV_W        = 10;
    localparam logic [9:0]  PCRS_SLOW_DIV_RST      = 10'h1e0;

    // Oscillator lock field
    localparam int          PCRS_OSCILLATOR_LOCKED_BIT      = 8;

    // Power and reset status fields
    localparam int          PCRS_HOST_CLK_BIT      = 11;
    localparam int          PCRS_LF_CLK_BIT        = 10;
    localparam int          PCRS_MAIN_RST_BIT      = 6;
    localparam int          PCRS_BAT_RST_BIT       = 5;
    localparam int          PCRS_HOST_RST_BIT      = 3;
    localparam int          PCRS_PWR_GOOD_BIT      = 2;
    localparam logic        PCRS_MAIN_RST_FLAG_RST = 1'b1;
    localparam logic        PCRS_BAT_RST_FLAG_RST  = 1'b0;

    // Clock presence windows: no sampled edge for this long means absent
    localparam int          PCRS_CLK_PERIOD_NS     = 40;
    localparam int          PCRS_HOST_WIN_NS       = 1000;
    localparam int          PCRS_LF_WIN_NS         = 100000;
    localparam int          PCRS_HOST_WIN_CYC      = PCRS_HOST_WIN_NS / PCRS_CLK_PERIOD_NS;
    localparam int          PCRS_LF_WIN_CYC        = PCRS_LF_WIN_NS / PCRS_CLK_PERIOD_NS;
    localparam int          PCRS_WIN_CNT_W         = 12;

    // AXI4-Lite responses
    localparam logic [1:0]  PCRS_RESP_OKAY         = 2'h0;
    localparam logic [1:0]  PCRS_RESP_SLVERR       = 2'h2;

endpackage : pcrs_pkg

`default_nettype wire

// >>> hdl/pcrs_top.sv
// Power, clock and reset status registers with AXI4-Lite access
//
// Summary of operation
// - Read-only clock-need flags at offset 28h
// - Fixed bit positions for each peripheral flag
// - Slow clock divides by field; zero or one stops
// - Divisor field resets to 1E0h
// - Oscillator lock flag at 30h bit 8
// - Bit 11 shows host bus clock edges
// - Bit 10 shows low-frequency clock edges
// - Low clock from pin or ring oscillator
// - Main-supply reset flag sticky, write-one clears
// - Main reset event beats coincident clear
// - Battery reset flag sticky, write-one clears
// - Battery event beats coincident clear
// - Bit 3 shows live host reset
// - Bit 2 shows live power-good
// - Live bits untouched by any reset
// - Sleep commands at 24h, same positions
`default_nettype none

module pcrs_top
    import pcrs_pkg::*;
#(
    parameter int                      DIV_W = PCRS_SLOW_DIV_W
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    // AXI4-Lite slave
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [7:0]            s_axi_awaddr_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    output logic [1:0]                 s_axi_bresp_o,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    input  wire logic [7:0]            s_axi_araddr_i,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i,
    output logic [31:0]                s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    // Peripheral side, same clock
    input  wire logic [31:0]           clock_need_i,
    output logic [31:0]                sleep_command_o,
    // Pins and other domains
    input  wire logic                  oscillator_locked_i,
    input  wire logic                  host_bus_clock_i,
    input  wire logic                  low_freq_clock_pin_i,
    input  wire logic                  ring_osc_clock_i,
    input  wire logic                  battery_reset_seen_i,
    input  wire logic                  host_side_reset_input_n_i,
    input  wire logic                  power_good_input_i,
    // Generated clocks and low clock pin presence flag
    output logic                       slow_clock_o,
    output logic                       low_freq_clock_o,
    output logic                       ring_osc_sync_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and clock monitors

    logic             lock_s1_reg;
    logic             lock_s2_reg;
    logic             bat_s1_reg;
    logic             bat_s2_reg;
    logic             hrst_s1_reg;
    logic             hrst_s2_reg;
    logic             pgood_s1_reg;
    logic             pgood_s2_reg;
    logic             ring_s1_reg;
    logic             ring_s2_reg;
    logic             host_clk_seen;
    logic             lf_clk_seen;
    logic             lf_clk_level;

    // Live inputs carry no reset so no reset event can disturb them
    always_ff @(posedge sys_clk_i) begin
        lock_s1_reg  <= oscillator_locked_i;
        lock_s2_reg  <= lock_s1_reg;
        bat_s1_reg   <= battery_reset_seen_i;
        bat_s2_reg   <= bat_s1_reg;
        hrst_s1_reg  <= host_side_reset_input_n_i;
        hrst_s2_reg  <= hrst_s1_reg;
        pgood_s1_reg <= power_good_input_i;
        pgood_s2_reg <= pgood_s1_reg;
        ring_s1_reg  <= ring_osc_clock_i;
        ring_s2_reg  <= ring_s1_reg;
    end

    pcrs_clock_monitor #(
        .CNT_W   (PCRS_WIN_CNT_W),
        .WIN_CYC (PCRS_WIN_CNT_W'(PCRS_HOST_WIN_CYC))
    ) u_host_mon (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .clk_pin_i (host_bus_clock_i),
        .level_o   (),
        .seen_o    (host_clk_seen)
    );

    pcrs_clock_monitor #(
        .CNT_W   (PCRS_WIN_CNT_W),
        .WIN_CYC (PCRS_WIN_CNT_W'(PCRS_LF_WIN_CYC))
    ) u_lf_mon (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .clk_pin_i (low_freq_clock_pin_i),
        .level_o   (lf_clk_level),
        .seen_o    (lf_clk_seen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave and registers

    logic             aw_full_reg;
    logic             aw_full_next;
    logic [7:0]       aw_addr_reg;
    logic [7:0]       aw_addr_next;
    logic             w_full_reg;
    logic             w_full_next;
    logic [31:0]      w_data_reg;
    logic [31:0]      w_data_next;
    logic [3:0]       w_strb_reg;
    logic [3:0]       w_strb_next;
    logic             bvalid_reg;
    logic             bvalid_next;
    logic [1:0]       bresp_reg;
    logic [1:0]       bresp_next;
    logic             rvalid_reg;
    logic             rvalid_next;
    logic [31:0]      rdata_reg;
    logic [31:0]      rdata_next;
    logic [1:0]       rresp_reg;
    logic [1:0]       rresp_next;
    logic [31:0]      sleep_reg;
    logic [31:0]      sleep_next;
    logic [31:0]      need_reg;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic             main_flag_reg;
    logic             main_flag_next;
    logic             bat_flag_reg;
    logic             bat_flag_next;
    logic             do_write;
    logic [31:0]      wmask;
    logic [31:0]      status_word;

    always_comb begin
        wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
        status_word = '0;
        status_word[PCRS_HOST_CLK_BIT] = host_clk_seen;
        status_word[PCRS_LF_CLK_BIT]   = lf_clk_seen;
        status_word[PCRS_MAIN_RST_BIT] = main_flag_reg;
        status_word[PCRS_BAT_RST_BIT]  = bat_flag_reg;
        status_word[PCRS_HOST_RST_BIT] = hrst_s2_reg;
        status_word[PCRS_PWR_GOOD_BIT] = pgood_s2_reg;
    end

    // Write happens once both halves are held and no response is pending
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

    always_comb begin
        aw_full_next   = aw_full_reg;
        aw_addr_next   = aw_addr_reg;
        w_full_next    = w_full_reg;
        w_data_next    = w_data_reg;
        w_strb_next    = w_strb_reg;
        bvalid_next    = bvalid_reg;
        bresp_next     = bresp_reg;
        sleep_next     = sleep_reg;
        div_next       = div_reg;
        main_flag_next = main_flag_reg;
        bat_flag_next  = bat_flag_reg;
        if (s_axi_awvalid_i && !aw_full_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_full_reg) begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata_i;
            w_strb_next = s_axi_wstrb_i;
        end
        if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = PCRS_RESP_OKAY;
            unique case (aw_addr_reg)
                PCRS_SLEEP_CMD_OFS: begin
                    sleep_next = ((sleep_reg & ~wmask) | (w_data_reg & wmask)) & PCRS_PERIPH_MASK;
                end
                PCRS_SLOW_DIV_OFS: begin
                    div_next = (div_reg & ~wmask[DIV_W-1:0]) | (w_data_reg[DIV_W-1:0] & wmask[DIV_W-1:0]);
                end
                PCRS_PWR_RST_OFS: begin
                    if (w_strb_reg[0] && w_data_reg[PCRS_MAIN_RST_BIT]) begin
                        main_flag_next = 1'b0;
                    end
                    if (w_strb_reg[0] && w_data_reg[PCRS_BAT_RST_BIT]) begin
                        bat_flag_next = 1'b0;
                    end
                end
                PCRS_CLK_NEED_OFS, PCRS_OSCILLATOR_LOCKED_OFS: begin
                    bresp_next = PCRS_RESP_OKAY;
                end
                default: begin
                    bresp_next = PCRS_RESP_SLVERR;
                end
            endcase
        end
        if (bat_s2_reg) begin
            bat_flag_next = 1'b1;
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && s_axi_rready_i) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid_i && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = PCRS_RESP_OKAY;
            rdata_next  = '0;
            unique case (s_axi_araddr_i)
                PCRS_SLEEP_CMD_OFS: begin
                    rdata_next = sleep_reg;
                end
                PCRS_CLK_NEED_OFS: begin
                    rdata_next = need_reg;
                end
                PCRS_SLOW_DIV_OFS: begin
                    rdata_next[DIV_W-1:0] = div_reg;
                end
                PCRS_OSCILLATOR_LOCKED_OFS: begin
                    rdata_next[PCRS_OSCILLATOR_LOCKED_BIT] = lock_s2_reg;
                end
                PCRS_PWR_RST_OFS: begin
                    rdata_next = status_word;
                end
                default: begin
                    rresp_next = PCRS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aw_full_reg   <= 1'b0;
            aw_addr_reg   <= '0;
            w_full_reg    <= 1'b0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
            bvalid_reg    <= 1'b0;
            bresp_reg     <= PCRS_RESP_OKAY;
            rvalid_reg    <= 1'b0;
            rdata_reg     <= '0;
            rresp_reg     <= PCRS_RESP_OKAY;
            sleep_reg     <= PCRS_SLEEP_CMD_RST;
            need_reg      <= '0;
            div_reg       <= PCRS_SLOW_DIV_RST;
            main_flag_reg <= PCRS_MAIN_RST_FLAG_RST;
            bat_flag_reg  <= PCRS_BAT_RST_FLAG_RST;
        end else begin
            aw_full_reg   <= aw_full_next;
            aw_addr_reg   <= aw_addr_next;
            w_full_reg    <= w_full_next;
            w_data_reg    <= w_data_next;
            w_strb_reg    <= w_strb_next;
            bvalid_reg    <= bvalid_next;
            bresp_reg     <= bresp_next;
            rvalid_reg    <= rvalid_next;
            rdata_reg     <= rdata_next;
            rresp_reg     <= rresp_next;
            sleep_reg     <= sleep_next;
            need_reg      <= clock_need_i & PCRS_PERIPH_MASK;
            div_reg       <= div_next;
            main_flag_reg <= main_flag_next;
            bat_flag_reg  <= bat_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slow clock divider and low-frequency clock select

    logic [DIV_W-1:0] div_cnt_reg;
    logic [DIV_W-1:0] div_cnt_next;
    logic [DIV_W-1:0] div_cur_reg;
    logic [DIV_W-1:0] div_cur_next;
    logic             slow_reg;
    logic             slow_next;
    logic             lfo_reg;
    logic             lfo_next;
    logic             rsync_reg;
    logic             rsync_next;

    always_comb begin
        div_cur_next = div_cur_reg;
        div_cnt_next = div_cnt_reg + DIV_W'(1);
        if ((div_cnt_reg >= div_cur_reg - DIV_W'(1)) || (div_cur_reg == '0)) begin
            div_cnt_next = '0;
            div_cur_next = div_reg;
        end
        slow_next = (div_cur_next != '0) && (div_cnt_next < (div_cur_next >> 1));
        lfo_next   = lf_clk_seen ? lf_clk_level : ring_s2_reg;
        rsync_next = lf_clk_seen;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            div_cnt_reg <= '0;
            div_cur_reg <= PCRS_SLOW_DIV_RST;
            slow_reg    <= 1'b0;
            lfo_reg     <= 1'b0;
            rsync_reg   <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            div_cur_reg <= div_cur_next;
            slow_reg    <= slow_next;
            lfo_reg     <= lfo_next;
            rsync_reg   <= rsync_next;
        end
    end

    assign s_axi_awready_o = !aw_full_reg;
    assign s_axi_wready_o  = !w_full_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign sleep_command_o = sleep_reg;
    assign slow_clock_o    = slow_reg;
    assign low_freq_clock_o = lfo_reg;
    assign ring_osc_sync_o = rsync_reg;

endmodule // pcrs_top

`default_nettype wire

// >>> tb/pcrs_periph_model.sv
// Peripheral-side model: blocks ask for their clock while busy and not told to sleep
`default_nettype none

module pcrs_periph_model #(
    parameter int LAG = 3
) (
    input  wire logic        sys_clk_i,
    input  wire logic [31:0] busy_i,
    input  wire logic [31:0] sleep_command_i,
    output logic      [31:0] clock_need_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] stage_reg [LAG];

    // sleep order obeyed
    // Blocks finish work before letting go of the clock, so the answer lags
    always @(posedge sys_clk_i) begin
        stage_reg[0] <= busy_i & ~sleep_command_i;
        for (int k = 1; k < LAG; k++)
            stage_reg[k] <= stage_reg[k-1];
    end

    assign clock_need_o = stage_reg[LAG-1];
endmodule // pcrs_periph_model

`default_nettype wire

// >>> tb/pcrs_top_asserts.sv
// Bus and register checks for the power, clock and reset status block
`default_nettype none

module pcrs_top_asserts
    import pcrs_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [7:0]  s_axi_araddr_i,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic [31:0] sleep_command_o,
    input wire logic        slow_clock_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    wire logic ar_go = s_axi_arvalid_i && s_axi_arready_o;
    wire logic wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;

    a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
        else $error("read response dropped early");
    a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address taken while answer pending");
    a_read_latency: assert property (ar_go |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_write_answer: assert property (wr_go && !s_axi_bvalid_o |-> ##[1:2] s_axi_bvalid_o)
        else $error("write answer late");
    a_reset_state: assert property (disable iff (1'b0) sys_rst_i |=> !s_axi_bvalid_o && !s_axi_rvalid_o &&
        !slow_clock_o && sleep_command_o == 32'h0)
        else $error("outputs not at reset values");
    a_sleep_mask: assert property ((sleep_command_o & ~PCRS_PERIPH_MASK) == 32'h0)
        else $error("sleep command outside block map");
    a_need_bits: assert property (ar_go && s_axi_araddr_i == PCRS_CLK_NEED_OFS |=>
        (s_axi_rdata_o & ~PCRS_PERIPH_MASK) == 32'h0 && s_axi_rresp_o == PCRS_RESP_OKAY)
        else $error("clock need read has stray bits");
    a_div_bits: assert property (ar_go && s_axi_araddr_i == PCRS_SLOW_DIV_OFS |=>
        s_axi_rdata_o[31:10] == 22'h0)
        else $error("divisor read wider than field");
    a_lock_bits: assert property (ar_go && s_axi_araddr_i == PCRS_OSCILLATOR_LOCKED_OFS |=>
        s_axi_rdata_o[31:9] == 23'h0 && s_axi_rdata_o[7:0] == 8'h0)
        else $error("lock read has stray bits");
    a_status_bits: assert property (ar_go && s_axi_araddr_i == PCRS_PWR_RST_OFS |=>
        (s_axi_rdata_o & 32'hfffff393) == 32'h0)
        else $error("status read has stray bits");

    c_write: cover property (wr_go);
    c_status_read: cover property (ar_go && s_axi_araddr_i == PCRS_PWR_RST_OFS);
    c_slow_rise: cover property ($rose(slow_clock_o));
endmodule // pcrs_top_asserts

bind pcrs_top pcrs_top_asserts u_pcrs_chk (.*);

`default_nettype wire

// >>> tb/pcrs_top_tb.sv
// Self-checking bench for the power, clock and reset status block
`default_nettype none

module pcrs_top_tb import pcrs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [1:0] OK = PCRS_RESP_OKAY;
    localparam logic [1:0] ERR = PCRS_RESP_SLVERR;
    logic        sys_clk, sys_rst, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic        ar_valid, ar_ready, r_valid, r_ready, oscillator_locked, host_clk, lf_pin, ring_clk;
    logic        bat_seen, host_rst_n, pwr_good, slow_clk, lf_clk, ring_sync, host_en, lf_en;
    logic [7:0]  aw_addr, ar_addr;
    logic [31:0] w_data, r_data, need, sleep_o, sleep, busy;
    logic [3:0]  w_strb;
    logic [1:0]  b_resp, r_resp;
    logic [33:0] exp_q [$];
    logic [31:0] seed = 32'h4c;
    int          mismatches, n_checks, p, h, i;

    pcrs_top DUT (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
        .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready), .s_axi_awaddr_i(aw_addr),
        .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready), .s_axi_wdata_i(w_data), .s_axi_wstrb_i(w_strb),
        .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready), .s_axi_bresp_o(b_resp),
        .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready), .s_axi_araddr_i(ar_addr),
        .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
        .clock_need_i(need), .sleep_command_o(sleep_o), .oscillator_locked_i(oscillator_locked),
        .host_bus_clock_i(host_clk), .low_freq_clock_pin_i(lf_pin), .ring_osc_clock_i(ring_clk),
        .battery_reset_seen_i(bat_seen), .host_side_reset_input_n_i(host_rst_n),
        .power_good_input_i(pwr_good), .slow_clock_o(slow_clk), .low_freq_clock_o(lf_clk),
        .ring_osc_sync_o(ring_sync)
    );
    pcrs_periph_model #(.LAG(3)) u_periph (
        .sys_clk_i(sys_clk), .busy_i(busy), .sleep_command_i(sleep_o), .clock_need_o(need)
    );

    initial begin
        sys_clk = 0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Pin clocks run free of the system clock phase
    always #15.1 if (host_en) host_clk = ~host_clk;
    always #15259 if (lf_en) lf_pin = ~lf_pin;
    always #1001 ring_clk = ~ring_clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bit ad, wd, ta, tw;
        exp_q.push_back({e, 32'h0});
        ad = 0;
        wd = 0;
        @(posedge sys_clk);
        {aw_valid, w_valid, b_ready, aw_addr, w_data} <= {3'b111, a, d};
        while (!(ad && wd)) begin
            @(negedge sys_clk);
            ta = aw_ready && !ad;
            tw = w_ready && !wd;
            @(posedge sys_clk);
            if (ta) aw_valid <= 0;
            if (tw) w_valid <= 0;
            ad |= ta;
            wd |= tw;
        end
        do @(negedge sys_clk); while (b_valid !== 1'b1);
        @(posedge sys_clk);
        b_ready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        exp_q.push_back({e, d});
        @(posedge sys_clk);
        {ar_valid, r_ready, ar_addr} <= {2'b11, a};
        do @(negedge sys_clk); while (ar_ready !== 1'b1);
        @(posedge sys_clk);
        ar_valid <= 0;
        do @(negedge sys_clk); while (r_valid !== 1'b1);
        @(posedge sys_clk);
        r_ready <= 0;
    endtask
    task automatic wait_lvl(input logic v, input int lim);
        i = 0;
        while (slow_clk !== v && i < lim) begin
            @(negedge sys_clk);
            i++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Answers are matched in order against the notes left by the bus tasks
    always @(posedge sys_clk) begin
        if (r_valid && r_ready)
            chk({r_resp, r_data}, exp_q.size() ? exp_q.pop_front() : 'x);
        if (b_valid && b_ready)
            chk({b_resp, 32'h0}, exp_q.size() ? exp_q.pop_front() : 'x);
    end

    initial begin
        cyc(20000);
        mismatches++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {aw_valid, w_valid, b_ready, ar_valid, r_ready, oscillator_locked, host_clk, lf_pin, ring_clk} = '0;
        {bat_seen, host_en, lf_en, aw_addr, ar_addr, w_data} = '0;
        {host_rst_n, pwr_good, w_strb} = 6'h3f;
        busy = xs();
        sys_rst = 1;
        cyc(5);
        sys_rst <= 0;
        cyc(6);
        rd(PCRS_SLOW_DIV_OFS, 32'h1e0, OK);
        rd(PCRS_OSCILLATOR_LOCKED_OFS, 32'h0, OK);
        rd(PCRS_PWR_RST_OFS, 32'h4c, OK);
        wr(PCRS_CLK_NEED_OFS, 32'hffffffff, OK);
        rd(PCRS_CLK_NEED_OFS, busy & PCRS_PERIPH_MASK, OK);
        rd(8'h38, 32'h0, ERR);
        wr(8'h20, 32'h1, ERR);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            sleep = (k == 0) ? '1 : xs();
            busy <= xs();
            wr(PCRS_SLEEP_CMD_OFS, sleep, OK);
            cyc(6);
            chk({2'b0, sleep_o}, {2'b0, sleep & PCRS_PERIPH_MASK});
            rd(PCRS_CLK_NEED_OFS, busy & ~sleep & PCRS_PERIPH_MASK, OK);
        end
        $display("test clock need done");
        wr(PCRS_PWR_RST_OFS, 32'h40, OK);
        rd(PCRS_PWR_RST_OFS, 32'h0c, OK);
        bat_seen <= 1;
        cyc(4);
        wr(PCRS_PWR_RST_OFS, 32'h20, OK);
        rd(PCRS_PWR_RST_OFS, 32'h2c, OK);
        bat_seen <= 0;
        cyc(4);
        wr(PCRS_PWR_RST_OFS, 32'h20, OK);
        rd(PCRS_PWR_RST_OFS, 32'h0c, OK);
        host_rst_n <= 0;
        sys_rst <= 1;
        cyc(5);
        sys_rst <= 0;
        cyc(4);
        rd(PCRS_PWR_RST_OFS, 32'h44, OK);
        {pwr_good, host_rst_n, oscillator_locked} <= 3'b011;
        cyc(4);
        rd(PCRS_OSCILLATOR_LOCKED_OFS, 32'h100, OK);
        rd(PCRS_PWR_RST_OFS, 32'h48, OK);
        pwr_good <= 1;
        $display("test flags done");
        host_en <= 1;
        cyc(20);
        rd(PCRS_PWR_RST_OFS, 32'h84c, OK);
        host_en <= 0;
        cyc(40);
        rd(PCRS_PWR_RST_OFS, 32'h4c, OK);
        lf_en <= 1;
        cyc(1600);
        rd(PCRS_PWR_RST_OFS, 32'h44c, OK);
        chk({33'h0, ring_sync}, 34'h1);
        @(lf_pin) cyc(9);
        chk({33'h0, lf_clk}, {33'h0, lf_pin});
        lf_en <= 0;
        cyc(3000);
        rd(PCRS_PWR_RST_OFS, 32'h4c, OK);
        chk({33'h0, ring_sync}, 34'h0);
        @(ring_clk) cyc(9);
        chk({33'h0, lf_clk}, {33'h0, ring_clk});
        $display("test clock presence done");
        wr(PCRS_SLOW_DIV_OFS, 32'h4, OK);
        cyc(1000);
        wait_lvl(0, 3000);
        wait_lvl(1, 3000);
        wait_lvl(0, 3000);
        h = i;
        wait_lvl(1, 3000);
        chk(34'(h + i), 34'h4);
        chk(34'(h), 34'h2);
        wr(PCRS_SLOW_DIV_OFS, 32'h0, OK);
        cyc(20);
        wait_lvl(1, 50);
        chk(34'(i), 34'd50);
        wr(PCRS_SLOW_DIV_OFS, 32'hfffffc07, OK);
        rd(PCRS_SLOW_DIV_OFS, 32'h7, OK);
        $display("test divider done");
        stop_test();
    end
endmodule // pcrs_top_tb

`default_nettype wire
